//--- logic/ssp_defines.svh
// Register offsets, field positions, reset values and timing for the port.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// Byte offsets of the registers
`define SSP_OFS_BAUD_CTRL   5'h00
`define SSP_OFS_RX_STATUS   5'h04
`define SSP_OFS_DIV_LOW     5'h08
`define SSP_OFS_DIV_HIGH    5'h0c
`define SSP_OFS_TX_HOLD     5'h10
`define SSP_OFS_TX_STATUS   5'h14
`define SSP_OFS_RX_HOLD     5'h18
`define SSP_ADDR_W          5

// serial_baud_control fields
`define SSP_BC_DATA_INV     5
`define SSP_BC_CLK_IDLE     4
`define SSP_BC_WIDE_DIV     3
// receive_status_control fields
`define SSP_RS_PORT_EN      7
`define SSP_RS_NINE_RX      6
`define SSP_RS_SINGLE_RX    5
`define SSP_RS_CONT_RX      4
`define SSP_RS_OVERRUN      1
`define SSP_RS_RX_NINTH     0
// transmit_status_control fields
`define SSP_TS_CLK_MASTER   7
`define SSP_TS_NINE_TX      6
`define SSP_TS_TX_EN        5
`define SSP_TS_SYNC         4
`define SSP_TS_HIGH_RATE    2
`define SSP_TS_SHIFT_EMPTY  1
`define SSP_TS_TX_NINTH     0

// Reset values
`define SSP_RST_BYTE        8'h00
`define SSP_RST_DIV         16'h0000

// Fifo depth and base prescale of the half-bit timer
`define SSP_RX_DEPTH        2
`define SSP_PRESCALE_LOW    4

`endif

//--- logic/ssp_pkg.sv
// Types shared by the serial port files.
// Assumes the defines header carries all numeric constants.
package ssp_pkg;

  // Link state of the shifter
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_TX   = 2'b01,
    SSP_RX   = 2'b10
  } ssp_state_t;

endpackage

//--- logic/ssp_half_bit_timer.sv
// Half-bit tick generator for the master bit clock.
// Assumes a divisor that is stable while a character is shifted.
`timescale 1ns/1ps
`include "ssp_defines.svh"

module ssp_half_bit_timer #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             wide_div,
  input  wire logic             high_rate,
  // Tick out
  output logic                  tick
);

  logic [DIV_W+1:0] count_reg;
  logic [DIV_W+1:0] limit;

  // Low rate stretches the period; narrow divisor uses the low byte only
  always_comb begin
    limit = wide_div ? {2'b00, divisor} : {10'h000, divisor[7:0]};
    if (!high_rate) begin
      limit = {limit[DIV_W-1:0], 2'b11} | 18'h00003;
    end
  end

  // Restart on every idle so the first half bit is full length
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      tick      <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      tick      <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= '0;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 18'h00001;
      tick      <= 1'b0;
    end
  end

endmodule // ssp_half_bit_timer

//--- logic/ssp_sync_port.sv
// Synchronous master serial port with a classic Wishbone register slave.
// Assumes the pad merges the output enables (low = drive) into the lines.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ssp_defines.svh"

module ssp_sync_port (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Clock line pad
  input  wire logic        clock_line_i,
  output logic             clock_line_o,
  output logic             clock_line_oe_n,
  // Data line pad
  input  wire logic        data_line_i,
  output logic             data_line_o,
  output logic             data_line_oe_n
);

  ssp_pkg::ssp_state_t state_reg;

  // Software registers
  logic [7:0]  baud_ctrl_reg;
  logic [7:0]  rx_ctrl_reg;
  logic [7:0]  tx_ctrl_reg;
  logic [15:0] divisor_reg;
  logic [7:0]  tx_hold_reg;
  logic        tx_hold_full_reg;
  logic        tx_hold_ninth_reg;
  // Shifter
  logic [8:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic        phase_reg;
  logic        ovr_single_reg;
  // Receive fifo
  logic [8:0]  fifo_mem [`SSP_RX_DEPTH];
  logic        rd_ptr_reg;
  logic [1:0]  fifo_cnt_reg;
  // Pin synchronisers
  logic [1:0]  data_sync_reg;
  logic [1:0]  clk_sync_reg;

  // Bit views
  logic port_en, sync_mode, master, tx_en, single_rx, cont_rx, overrun;
  logic nine_tx, nine_rx, clk_idle, data_inv, rx_dir, master_on;
  assign port_en   = rx_ctrl_reg[`SSP_RS_PORT_EN];
  assign sync_mode = tx_ctrl_reg[`SSP_TS_SYNC];
  assign master    = tx_ctrl_reg[`SSP_TS_CLK_MASTER];
  assign tx_en     = tx_ctrl_reg[`SSP_TS_TX_EN];
  assign single_rx = rx_ctrl_reg[`SSP_RS_SINGLE_RX];
  assign cont_rx   = rx_ctrl_reg[`SSP_RS_CONT_RX];
  assign overrun   = rx_ctrl_reg[`SSP_RS_OVERRUN];
  assign nine_tx   = tx_ctrl_reg[`SSP_TS_NINE_TX];
  assign nine_rx   = rx_ctrl_reg[`SSP_RS_NINE_RX];
  assign clk_idle  = baud_ctrl_reg[`SSP_BC_CLK_IDLE];
  assign data_inv  = baud_ctrl_reg[`SSP_BC_DATA_INV];
  assign master_on = port_en && sync_mode && master;
  assign rx_dir    = single_rx || cont_rx;

  // Bus decode
  logic wb_req, wb_wr, wb_rd, wr_lo;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;
  assign wb_rd  = wb_req && !wb_we_i;
  assign wr_lo  = wb_wr && wb_sel_i[0];

  function automatic logic hit(input logic [4:0] adr,
                               input logic [4:0] ofs);
    hit = (adr[4:2] == ofs[4:2]);
  endfunction

  // Character and shift control
  logic tick, busy, rx_done, tx_done, rx_abort, rx_start, tx_start;
  logic [3:0] char_bits;
  logic rd_hold, push_ok;
  assign busy      = (state_reg != ssp_pkg::SSP_IDLE);
  assign rd_hold   = wb_rd && hit(wb_adr_i, `SSP_OFS_RX_HOLD);
  assign tx_start  = master_on && tx_en && !rx_dir && tx_hold_full_reg &&
                     !busy;
  assign rx_start  = master_on && rx_dir && !overrun && !busy;
  assign rx_abort  = (state_reg == ssp_pkg::SSP_RX) &&
                     (!master_on || !rx_dir);
  assign char_bits = (state_reg == ssp_pkg::SSP_TX) ?
                     (nine_tx ? 4'h9 : 4'h8) : (nine_rx ? 4'h9 : 4'h8);
  // Trailing half-bit of the last bit ends the character
  assign rx_done   = (state_reg == ssp_pkg::SSP_RX) && !rx_abort && tick &&
                     phase_reg && (bit_cnt_reg == char_bits - 4'h1);
  assign tx_done   = (state_reg == ssp_pkg::SSP_TX) && tick && phase_reg &&
                     (bit_cnt_reg == char_bits - 4'h1);
  assign push_ok   = (fifo_cnt_reg != 2'(`SSP_RX_DEPTH));

  // Trailing-edge sample merged into the word. The push takes this same
  // value, so the last bit is not lost on the completing edge. The pin
  // lags by the two sync flops, well inside one half bit.
  logic [8:0] rx_shift_next;
  logic       rx_bit;
  assign rx_bit        = data_sync_reg[1] ^ data_inv;
  assign rx_shift_next = nine_rx ? {rx_bit, shift_reg[8:1]} :
                         {1'b0, rx_bit, shift_reg[7:1]};

  ssp_half_bit_timer #(
    .DIV_W     (16)
  ) u_timer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .run       (busy && !rx_abort),
    .divisor   (divisor_reg),
    .wide_div  (baud_ctrl_reg[`SSP_BC_WIDE_DIV]),
    .high_rate (tx_ctrl_reg[`SSP_TS_HIGH_RATE]),
    .tick      (tick)
  );

  // Two flops on the pins; the slave clock is only observed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_sync_reg <= 2'b00;
      clk_sync_reg  <= 2'b00;
    end else begin
      data_sync_reg <= {data_sync_reg[0], data_line_i};
      clk_sync_reg  <= {clk_sync_reg[0], clock_line_i};
    end
  end

  // Wishbone: one-cycle registered ack, unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_rd) begin
        case (wb_adr_i[4:2])
          3'h0: wb_dat_o[7:0] <= baud_ctrl_reg & 8'h38;
          3'h1: wb_dat_o[7:0] <= {rx_ctrl_reg[7:1],
                                  fifo_mem[rd_ptr_reg][8]};
          3'h2: wb_dat_o[7:0] <= divisor_reg[7:0];
          3'h3: wb_dat_o[7:0] <= divisor_reg[15:8];
          3'h5: wb_dat_o[7:0] <= {tx_ctrl_reg[7:2],
                                  state_reg != ssp_pkg::SSP_TX,
                                  tx_hold_ninth_reg};
          3'h6: wb_dat_o[7:0] <= fifo_mem[rd_ptr_reg][7:0];
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_ctrl_reg     <= `SSP_RST_BYTE;
      tx_ctrl_reg       <= `SSP_RST_BYTE;
      divisor_reg       <= `SSP_RST_DIV;
      tx_hold_ninth_reg <= 1'b0;
    end else if (wr_lo) begin
      if (hit(wb_adr_i, `SSP_OFS_BAUD_CTRL)) begin
        baud_ctrl_reg <= wb_dat_i[7:0] & 8'h38;
      end
      if (hit(wb_adr_i, `SSP_OFS_DIV_LOW)) begin
        divisor_reg[7:0] <= wb_dat_i[7:0];
      end
      if (hit(wb_adr_i, `SSP_OFS_DIV_HIGH)) begin
        divisor_reg[15:8] <= wb_dat_i[7:0];
      end
      if (hit(wb_adr_i, `SSP_OFS_TX_STATUS)) begin
        tx_ctrl_reg       <= wb_dat_i[7:0] & 8'hfc;
        tx_hold_ninth_reg <= wb_dat_i[`SSP_TS_TX_NINTH];
      end
    end
  end

  // Overrun clear causes: a holding read after a single receive, leaving
  // continuous mode, or turning the port off; a new overrun still wins
  logic ovr_clear;
  assign ovr_clear = (ovr_single_reg && rd_hold) ||
                     (!cont_rx && !ovr_single_reg) || !port_en;

  // Receive control; hardware clear of single receive beats software
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_reg    <= `SSP_RST_BYTE;
      ovr_single_reg <= 1'b0;
    end else begin
      if (wr_lo && hit(wb_adr_i, `SSP_OFS_RX_STATUS)) begin
        rx_ctrl_reg[7:4] <= wb_dat_i[7:4];
      end
      if (rx_done) begin
        rx_ctrl_reg[`SSP_RS_SINGLE_RX] <= 1'b0;
        if (!push_ok) begin
          rx_ctrl_reg[`SSP_RS_OVERRUN] <= 1'b1;
          ovr_single_reg <= !cont_rx;
        end
      end else if (overrun) begin
        // Clearing a cause wins only when no new overrun arrives
        if (ovr_clear) begin
          rx_ctrl_reg[`SSP_RS_OVERRUN] <= 1'b0;
        end
      end
    end
  end

  // Holding register: write fills, start of a character empties
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_reg      <= `SSP_RST_BYTE;
      tx_hold_full_reg <= 1'b0;
    end else if (!port_en) begin
      tx_hold_full_reg <= 1'b0;
    end else if (wr_lo && hit(wb_adr_i, `SSP_OFS_TX_HOLD)) begin
      tx_hold_reg      <= wb_dat_i[7:0];
      tx_hold_full_reg <= 1'b1;
    end else if (tx_start) begin
      // A write on the start edge wins: the old byte is already taken
      tx_hold_full_reg <= 1'b0;
    end
  end

  // Shifter: phase 0 is the leading half, phase 1 the trailing half
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ssp_pkg::SSP_IDLE;
      shift_reg   <= 9'h000;
      bit_cnt_reg <= 4'h0;
      phase_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ssp_pkg::SSP_IDLE: begin
          phase_reg   <= 1'b0;
          bit_cnt_reg <= 4'h0;
          if (tx_start) begin
            shift_reg <= {tx_hold_ninth_reg, tx_hold_reg};
            state_reg <= ssp_pkg::SSP_TX;
          end else if (rx_start) begin
            state_reg <= ssp_pkg::SSP_RX;
          end
        end
        ssp_pkg::SSP_TX, ssp_pkg::SSP_RX: begin
          if (rx_abort || !master_on) begin
            state_reg <= ssp_pkg::SSP_IDLE;
          end else if (tick) begin
            phase_reg <= !phase_reg;
            if (phase_reg) begin
              // Trailing edge: transmit moves on, receive samples
              if (state_reg == ssp_pkg::SSP_TX) begin
                shift_reg <= {1'b0, shift_reg[8:1]};
              end else begin
                shift_reg <= rx_shift_next;
              end
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (tx_done || rx_done) begin
                state_reg <= ssp_pkg::SSP_IDLE;
              end
            end
          end
        end
        default: state_reg <= ssp_pkg::SSP_IDLE;
      endcase
    end
  end

  // Receive fifo: push on completion, pop on holding read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg   <= 1'b0;
      fifo_cnt_reg <= 2'b00;
      fifo_mem[0]  <= 9'h000;
      fifo_mem[1]  <= 9'h000;
    end else if (!port_en) begin
      rd_ptr_reg   <= 1'b0;
      fifo_cnt_reg <= 2'b00;
    end else begin
      if (rx_done && push_ok && !overrun) begin
        fifo_mem[rd_ptr_reg ^ fifo_cnt_reg[0]] <= rx_shift_next;
      end
      if (rd_hold && fifo_cnt_reg != 2'b00) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg +
        2'(rx_done && push_ok && !overrun) -
        2'(rd_hold && fifo_cnt_reg != 2'b00);
    end
  end

  // Pins: clock toggles per half bit, data set in the leading half
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_line_o    <= 1'b0;
      clock_line_oe_n <= 1'b1;
      data_line_o     <= 1'b0;
      data_line_oe_n  <= 1'b1;
    end else begin
      clock_line_oe_n <= !(master_on && (tx_en || rx_dir));
      data_line_oe_n  <= !(master_on && tx_en && !rx_dir);
      if (!busy || rx_abort) begin
        clock_line_o <= clk_idle;
      end else if (tick) begin
        clock_line_o <= phase_reg ? clk_idle : !clk_idle;
      end
      if (state_reg == ssp_pkg::SSP_TX && tick && !phase_reg) begin
        data_line_o <= shift_reg[0] ^ data_inv;
      end
    end
  end

endmodule // ssp_sync_port

//--- dv/ssp_sync_port_props.sv
// Checker for the port's bus timing and line behaviour.
// Assumes it is bound to ssp_sync_port and sees only its ports.
`timescale 1ns/1ps

module ssp_sync_port_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Lines
  input wire logic        clock_line_o,
  input wire logic        clock_line_oe_n,
  input wire logic        data_line_o,
  input wire logic        data_line_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic tk;
  logic rxw;
  logic cfg;
  logic idle_q;
  logic en_q;
  logic ms_q;
  logic dchg_q;

  // Taken request and shadow copies of the enables
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rxw = tk && wb_we_i && wb_adr_i == 5'h04;
  assign cfg = en_q && ms_q;

  // Shadows follow bus writes; polarity gives the trailing edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 1'b0;
      en_q <= 1'b0;
      ms_q <= 1'b0;
      dchg_q <= 1'b0;
    end else begin
      dchg_q <= $changed(data_line_o);
      if (tk && wb_we_i && wb_adr_i == 5'h00)
        idle_q <= wb_dat_i[4];
      if (rxw)
        en_q <= wb_dat_i[7];
      if (tk && wb_we_i && wb_adr_i == 5'h14)
        ms_q <= wb_dat_i[7] && wb_dat_i[4];
    end
  end

  property p_ack_resp;
    tk |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack timing");

  property p_ack_cause;
    wb_ack_o |-> $past(tk);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");

  property p_rd_zero;
    tk && !wb_we_i |=> wb_dat_o[31:8] == 24'h000000 &&
      (wb_adr_i != 5'h1c && wb_adr_i != 5'h10 || wb_dat_o[7:0] == 8'h00);
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read not zero");

  property p_clk_drive;
    !clock_line_oe_n |-> $past(cfg);
  endproperty
  a_clk_drive: assert property (p_clk_drive) else $error("clock driven");

  property p_half_dup;
    !data_line_oe_n |-> !clock_line_oe_n;
  endproperty
  a_half_dup: assert property (p_half_dup) else $error("data alone");

  property p_rx_release;
    rxw && (wb_dat_i[5] || wb_dat_i[4]) |-> ##3 data_line_oe_n;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("rx drive");

  property p_cont_stop;
    rxw && wb_dat_i[7] && wb_dat_i[5:4] == 2'b00
      |-> ##3 $stable(clock_line_o) [*8];
  endproperty
  a_cont_stop: assert property (p_cont_stop) else $error("clock on");

  property p_data_hold;
    $changed(clock_line_o) && clock_line_o == idle_q && !data_line_oe_n &&
      !$past(data_line_oe_n) && !$past(data_line_oe_n, 2)
      |-> $stable(data_line_o) && !dchg_q;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");

  c_write: cover property (tk && wb_we_i);
  c_tx: cover property ($fell(data_line_oe_n));
  c_rx: cover property (rxw && wb_dat_i[5]);
endmodule // ssp_sync_port_props

bind ssp_sync_port ssp_sync_port_props ssp_sync_port_props_inst (
  .ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .clock_line_o, .clock_line_oe_n, .data_line_o,
  .data_line_oe_n);

//--- dv/ssp_slave_model.sv
// Behavioural slave on the far side of the two lines.
// Assumes the bench resolves the line levels with pull-ups.
`timescale 1ns/1ps

module ssp_slave_model (
  // Clock and line levels
  input  wire logic       ref_clk,
  input  wire logic       ck,
  input  wire logic       dl,
  // Set-up from the bench
  input  wire logic       idle,
  input  wire logic       nine,
  input  wire logic       drive,
  input  wire logic       clr,
  input  wire logic [8:0] tx_word,
  // Line drive and capture
  output logic            dt_o,
  output logic            dt_oe_n,
  output logic [8:0]      rx_word,
  output int              edges
);
  logic       ck_q;
  logic [3:0] bi;

  initial begin
    ck_q = 1'b1;
    dt_o = 1'b0;
    dt_oe_n = 1'b1;
    rx_word = 9'h000;
    edges = 0;
    bi = 4'h0;
  end

  // Edges seen on the clock line; one bit per cycle, lsb first
  always @(posedge ref_clk) begin
    ck_q <= ck;
    dt_oe_n <= !drive;
    if (clr) begin
      edges <= 0;
      bi <= 4'h0;
    end else if (ck != ck_q && ck != idle) begin
      dt_o <= tx_word[bi];
    end else if (ck != ck_q) begin
      rx_word <= {dl, rx_word[8:1]};
      edges <= edges + 1;
      bi <= (bi == (nine ? 4'h8 : 4'h7)) ? 4'h0 : bi + 4'h1;
    end
  end
endmodule // ssp_slave_model

//--- dv/tb_sync_serial_master_port.sv
// Testbench for the synchronous master serial port.
// Assumes pull-ups on both lines and the slave model on the far side.
`timescale 1ns/1ps

`define CHK(nm, ex, ac) begin \
  checked++; \
  if ((ac) !== (ex)) begin \
    fails++; \
    $display("mismatch %s exp %h got %h", nm, ex, ac); \
  end \
end

module tb_sync_serial_master_port;
  logic        ref_clk, rst_n, cyc, stb, we, clr;
  logic        ack, ck_o, ck_oe_n, dt_o, dt_oe_n, m_o, m_oe_n;
  logic        idle, nine, drive;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat;
  logic [8:0]  tx_word, rx_word;
  logic [7:0]  rd;
  logic        ck, dl;
  int          edges, fails, checked;

  // Released lines read high
  assign ck = ck_oe_n ? 1'b1 : ck_o;
  assign dl = !dt_oe_n ? dt_o : (!m_oe_n ? m_o : 1'b1);

  ssp_sync_port ssp_sync_port_inst (
    .ref_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .clock_line_i(ck), .clock_line_o(ck_o),
    .clock_line_oe_n(ck_oe_n), .data_line_i(dl), .data_line_o(dt_o),
    .data_line_oe_n(dt_oe_n));

  ssp_slave_model ssp_slave_model_inst (
    .ref_clk, .ck, .dl, .idle, .nine, .drive, .clr, .tx_word,
    .dt_o(m_o), .dt_oe_n(m_oe_n), .rx_word, .edges);

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // One classic cycle; holds until ack, no latency assumed
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_edges(input int e);
    while (edges < e) begin
      @(posedge ref_clk);
    end
  endtask

  // Port off while polarity changes, then master set-up
  task automatic cfg(input logic [7:0] bc, input logic [7:0] tc);
    xfer(1'b1, 5'h04, 8'h00);
    xfer(1'b1, 5'h00, bc);
    xfer(1'b1, 5'h14, tc);
    xfer(1'b1, 5'h08, 8'h05);
    xfer(1'b1, 5'h04, 8'h80);
    repeat (20) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Run takes under two thousand cycles; this cuts a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    report_and_stop;
  end

  initial begin
    int n;
    {rst_n, cyc, stb, we, clr, idle, nine, drive} = 8'h00;
    adr = 5'h00;
    wdat = 32'h00000000;
    tx_word = 9'h000;
    fails = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    xfer(1'b0, 5'h00, 8'h00);
    `CHK("baud_ctrl", 8'h00, rd)
    xfer(1'b0, 5'h04, 8'h00);
    `CHK("rx_ctrl", 8'h00, rd)
    xfer(1'b1, 5'h08, 8'h5c);
    xfer(1'b0, 5'h08, 8'h00);
    `CHK("div_low", 8'h5c, rd)
    xfer(1'b0, 5'h10, 8'h00);
    `CHK("tx_hold", 8'h00, rd)
    xfer(1'b0, 5'h1c, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    $display("done registers");
    cfg(8'h00, 8'hb4);
    `CHK("ck_idle", 1'b0, ck_o)
    `CHK("ck_oe_n", 1'b0, ck_oe_n)
    xfer(1'b1, 5'h10, 8'ha5);
    xfer(1'b1, 5'h10, 8'h3c);
    wait_edges(8);
    `CHK("tx_first", 8'ha5, rx_word[8:1])
    wait_edges(16);
    `CHK("tx_second", 8'h3c, rx_word[8:1])
    repeat (80) @(posedge ref_clk);
    `CHK("tx_clocks", 16, edges)
    xfer(1'b0, 5'h14, 8'h00);
    `CHK("tx_ctrl", 8'hb6, rd)
    $display("done transmit");
    idle <= 1'b1;
    nine <= 1'b1;
    cfg(8'h30, 8'hf5);
    `CHK("ck_idle_hi", 1'b1, ck_o)
    xfer(1'b1, 5'h10, 8'h5a);
    wait_edges(9);
    `CHK("tx_nine_inv", 9'h0a5, rx_word)
    repeat (80) @(posedge ref_clk);
    `CHK("tx9_clocks", 9, edges)
    $display("done nine bit transmit");
    idle <= 1'b0;
    tx_word <= 9'h1c3;
    cfg(8'h00, 8'hb4);
    xfer(1'b1, 5'h04, 8'he0);
    drive <= 1'b1;
    rd = 8'hff;
    for (n = 0; n < 300 && rd[5] !== 1'b0; n++)
      xfer(1'b0, 5'h04, 8'h00);
    `CHK("rx_single", 8'hc1, rd)
    xfer(1'b0, 5'h18, 8'h00);
    `CHK("rx_hold", 8'hc3, rd)
    repeat (60) @(posedge ref_clk);
    `CHK("rx_clocks", 9, edges)
    $display("done single receive");
    nine <= 1'b0;
    drive <= 1'b0;
    tx_word <= 9'h0a6;
    cfg(8'h00, 8'hb4);
    xfer(1'b1, 5'h04, 8'h90);
    drive <= 1'b1;
    wait_edges(24);
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, 5'h04, 8'h00);
    `CHK("rx_overrun", 8'h92, rd)
    for (n = 0; n < 2; n++) begin
      xfer(1'b0, 5'h18, 8'h00);
      `CHK("rx_kept", 8'ha6, rd)
    end
    xfer(1'b1, 5'h04, 8'h80);
    xfer(1'b0, 5'h04, 8'h00);
    `CHK("ovr_clear", 8'h80, rd)
    xfer(1'b1, 5'h04, 8'h90);
    wait_edges(27);
    xfer(1'b1, 5'h04, 8'h80);
    repeat (60) @(posedge ref_clk);
    `CHK("cont_stop", 27, edges)
    $display("done continuous receive");
    report_and_stop;
  end
endmodule // tb_sync_serial_master_port
